// >>> ics_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// [RULE_01] two-bit opcode: stop, chain, link, stop-now
// [RULE_02] address wrap carry toggles data address bit15
// [RULE_03] wrap on index toggles control word index
// [RULE_04] flag shows bit15 of address or index
// [RULE_05] count-zero flag after byte count update
// [RULE_06] separate buffer-done and control-byte pending flags
// [RULE_07] null-status flag on all-zero status byte
// [RULE_08] flag rejected data or status request
// [RULE_09] separate upper and lower byte store strobes
// [RULE_10] bootstrap steps: device, transfer, index, count
// [RULE_11] last bootstrap step stores address, sets wait
// [RULE_12] bootstrap advances only while allowed; busy flag
// [RULE_13] end status: clear buffer, lockout, transfer
// [RULE_14] start status step two: address off, service on
// [RULE_15] held flag while input byte awaits transfer
// [RULE_16] attention pending until channel accepts status
// [RULE_17] unit exception pending until channel accepts
// [RULE_18] descending: minus one per byte, four per status
// [RULE_19] address-in step two: command tag, priority request
// [RULE_20] tags stay set until a step clears them
// [RULE_21] sequence steps ascend one per clock unless stalled
module ics_sequencer
	import ics_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// peripheral inputs
	input wire logic [7:0] busIn,
	input wire logic dataInValid,
	input wire logic statusValid,
	input wire logic addressInTag,
	input wire logic rejectIn,
	input wire logic attnSwitch,
	input wire logic unitExcSwitch,
	// outgoing tags
	output logic selectOutTag,
	output logic addressOutTag,
	output logic serviceOutTag,
	output logic commandOutTag,
	output logic chanPriorityReq,
	// storage port
	output logic [15:0] storeAddr,
	output logic [15:0] storeData,
	output logic storeWrUpper,
	output logic storeWrLower
);
	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic ackReg, descReg, allowReg, runReg, cmpEnReg;
	logic [15:0] dataAddrReg, countReg, indexReg, transferReg, workReg;
	logic [1:0] opReg;
	logic [7:0] cmpByteReg, deviceReg, inputReg;
	logic bufDoneReg, ctrlByteReg, rejectReg, nullStaReg, countZeroReg, heldReg;
	logic attnReg, unitExcReg, loadingReg, waitReg, chainReqReg, lockoutReg;
	ics_boot_e bootReg;
	ics_seq_e seqReg;
	logic wrAcc, rdAcc, bootGo, statGo, byteGo, statusStore, lastByte;
	logic [15:0] addrNext, indexNext, countNext, flagWord, flagClr;
	logic addrWrap, indexWrap, chainStep, stopHit;

	// -------------------------------------------------------------
	// bus slave
	// -------------------------------------------------------------
	// one wait state: ack raised the cycle after a request appears
	assign waitrequest = (read | write) & ~ackReg;
	assign wrAcc = write & ackReg;
	assign rdAcc = read & ~ackReg;
	assign bootGo = wrAcc && address == OFS_CTRL && writedata[CTL_BOOT_GO];
	assign statGo = wrAcc && address == OFS_CTRL && writedata[CTL_STAT_GO];

	// acknowledge toggle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ackReg <= 1'b0;
		end else begin
			ackReg <= (read | write) & ~ackReg;
		end
	end

	// flag word seen by software
	always_comb begin
		flagWord = RST_WORD;
		flagWord[FL_BUF_DONE] = bufDoneReg;
		flagWord[FL_CTRL_BYTE] = ctrlByteReg;
		flagWord[FL_REJECT] = rejectReg;
		flagWord[FL_NULL_STA] = nullStaReg;
		flagWord[FL_COUNT_ZERO] = countZeroReg;
		// [RULE_04] bit15 indicator
		flagWord[FL_BIT15] = dataAddrReg[15] | indexReg[15];
		flagWord[FL_HELD] = heldReg;
		flagWord[FL_ATTN] = attnReg;
		flagWord[FL_UNIT_EXC] = unitExcReg;
		flagWord[FL_LOADING] = loadingReg;
		flagWord[FL_WAIT] = waitReg;
		flagWord[FL_CHAIN_REQ] = chainReqReg;
		flagWord[FL_LOCKOUT] = lockoutReg;
	end

	// read data, registered during the wait cycle; unmapped reads zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			readdata <= 32'h00000000;
		end else if (rdAcc) begin
			case (address)
				OFS_CTRL: readdata <= {28'h0000000, cmpEnReg, runReg, allowReg, descReg};
				OFS_FLAGS: readdata <= {16'h0000, flagWord};
				OFS_DATA_ADDR: readdata <= {16'h0000, dataAddrReg};
				OFS_BYTE_COUNT: readdata <= {16'h0000, countReg};
				OFS_INDEX: readdata <= {16'h0000, indexReg};
				OFS_BCW: readdata <= {16'h0000, cmpByteReg, 6'h00, opReg};
				OFS_DEVICE: readdata <= {8'h00, transferReg, deviceReg};
				default: readdata <= 32'h00000000;
			endcase
		end
	end

	// control register; hardware stop clears run
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{descReg, allowReg, runReg, cmpEnReg} <= 4'h0;
			opReg <= OP_STOP;
			cmpByteReg <= RST_BYTE;
		end else begin
			if (wrAcc && address == OFS_CTRL) begin
				descReg <= writedata[CTL_DESC];
				allowReg <= writedata[CTL_ALLOW];
				runReg <= writedata[CTL_RUN];
				cmpEnReg <= writedata[CTL_CMP_EN];
			end else if (stopHit) begin
				runReg <= 1'b0;
			end
			if (wrAcc && address == OFS_BCW) begin
				opReg <= writedata[1:0];
				cmpByteReg <= writedata[15:8];
			end
		end
	end

	// -------------------------------------------------------------
	// address, count and index update
	// -------------------------------------------------------------
	ics_addr_step dataStep (
		.value(dataAddrReg),
		.descending(descReg),
		.stepAmount(statusStore ? STEP_STATUS : STEP_BYTE),
		.nextValue(addrNext),
		.wrapCarry(addrWrap)
	);
	ics_addr_step indexStep (
		.value(indexReg),
		.descending(1'b0),
		.stepAmount(STEP_BYTE),
		.nextValue(indexNext),
		.wrapCarry(indexWrap)
	);

	assign statusStore = seqReg == SQ_WAITSTA && statusValid;
	assign byteGo = heldReg && runReg && countReg != RST_WORD && bootReg == BT_IDLE && !statusStore;
	assign countNext = countReg - COUNT_ONE;
	assign lastByte = byteGo && countNext == RST_WORD;
	// [RULE_01] opcode decode at buffer end
	assign chainStep = lastByte && opReg == OP_CHAIN;
	assign stopHit = lastByte && (opReg == OP_STOP || opReg == OP_STOP_NOW);

	// data address and count
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			dataAddrReg <= RST_WORD;
			countReg <= RST_WORD;
			countZeroReg <= 1'b0;
		end else begin
			if (wrAcc && address == OFS_DATA_ADDR) begin
				dataAddrReg <= writedata[15:0];
			end else if (byteGo || statusStore) begin
				// [RULE_02] [RULE_18] step with wrap toggle
				dataAddrReg <= addrNext;
			end
			if (wrAcc && address == OFS_BYTE_COUNT) begin
				countReg <= writedata[15:0];
				countZeroReg <= writedata[15:0] == RST_WORD;
			end else if (byteGo) begin
				// [RULE_05] count-zero on update
				countReg <= countNext;
				countZeroReg <= countNext == RST_WORD;
			end
		end
	end

	// control word index
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			indexReg <= RST_WORD;
		end else if (wrAcc && address == OFS_INDEX) begin
			indexReg <= writedata[15:0];
		end else if (chainStep) begin
			// [RULE_03] index step with toggle
			indexReg <= indexNext;
		end
	end

	// -------------------------------------------------------------
	// input byte holding
	// -------------------------------------------------------------
	// a new byte on the same edge as a store or as the SQ_END1 clear of a held byte is refused and the flag clears
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			heldReg <= 1'b0;
			inputReg <= RST_BYTE;
		end else if (dataInValid && !heldReg) begin
			// [RULE_15] hold input byte
			heldReg <= 1'b1;
			inputReg <= busIn;
		end else if (byteGo || seqReg == SQ_END1) begin
			heldReg <= 1'b0;
		end
	end

	// -------------------------------------------------------------
	// sticky flags, set wins; write one clears only buffer done, control byte, reject, null status, wait and chain request
	// -------------------------------------------------------------
	// clear mask from a flag register write
	assign flagClr = (wrAcc && address == OFS_FLAGS) ? writedata[15:0] : RST_WORD;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{bufDoneReg, ctrlByteReg, rejectReg, nullStaReg, waitReg, chainReqReg} <= 6'h00;
		end else begin
			// [RULE_06] separate pending interrupts
			bufDoneReg <= (bufDoneReg & ~flagClr[FL_BUF_DONE]) | (lastByte && opReg == OP_STOP);
			ctrlByteReg <= (ctrlByteReg & ~flagClr[FL_CTRL_BYTE]) | (byteGo && cmpEnReg && inputReg == cmpByteReg);
			// [RULE_08] overrun or refused request
			rejectReg <= (rejectReg & ~flagClr[FL_REJECT]) | rejectIn | (dataInValid && heldReg);
			// [RULE_07] null status
			nullStaReg <= (nullStaReg & ~flagClr[FL_NULL_STA]) | (statusStore && busIn == RST_BYTE);
			waitReg <= (waitReg & ~flagClr[FL_WAIT]) | (bootReg == BT_ADR && allowReg);
			chainReqReg <= (chainReqReg & ~flagClr[FL_CHAIN_REQ]) | (lastByte && opReg == OP_LINK) | chainStep;
		end
	end

	// attention and unit exception held until status is accepted
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			attnReg <= 1'b0;
			unitExcReg <= 1'b0;
		end else begin
			// [RULE_16] attention pending
			attnReg <= attnSwitch | (attnReg & seqReg != SQ_END1);
			// [RULE_17] unit exception pending
			unitExcReg <= unitExcSwitch | (unitExcReg & seqReg != SQ_END1);
		end
	end

	// -------------------------------------------------------------
	// bootstrap load
	// -------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bootReg <= BT_IDLE;
			loadingReg <= 1'b0;
			workReg <= RST_WORD;
		end else if (bootReg == BT_IDLE) begin
			if (bootGo && allowReg) begin
				bootReg <= BT_DEV;
				loadingReg <= 1'b1;
			end
		end else if (allowReg) begin
			// [RULE_12] [RULE_21] advance only while allowed
			case (bootReg)
				BT_DEV: begin
					// [RULE_10] device number in
					workReg <= {8'h00, deviceReg};
					bootReg <= BT_XFER;
				end
				BT_XFER: bootReg <= BT_IDX;
				BT_IDX: bootReg <= BT_CNT;
				BT_CNT: bootReg <= BT_ADR;
				BT_ADR: begin
					// [RULE_11] last step ends load
					bootReg <= BT_IDLE;
					loadingReg <= 1'b0;
				end
				default: bootReg <= BT_IDLE;
			endcase
		end
	end

	// -------------------------------------------------------------
	// status and address-in sequences, interface tags
	// -------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			seqReg <= SQ_IDLE;
			{selectOutTag, addressOutTag, serviceOutTag, commandOutTag} <= 4'h0;
			chanPriorityReq <= 1'b0;
			lockoutReg <= 1'b0;
			deviceReg <= RST_BYTE;
			transferReg <= RST_WORD;
		end else begin
			if (wrAcc && address == OFS_DEVICE) begin
				deviceReg <= writedata[7:0];
			end
			if (bootReg == BT_XFER && allowReg) begin
				transferReg <= workReg;
			end
			// [RULE_20] [RULE_21] tags change only in steps
			case (seqReg)
				SQ_IDLE: begin
					if (statGo) begin
						seqReg <= SQ_START1;
						selectOutTag <= 1'b1;
						addressOutTag <= 1'b1;
						lockoutReg <= 1'b1;
					end else if (addressInTag) begin
						seqReg <= SQ_ADRIN1;
					end
				end
				SQ_START1: seqReg <= SQ_START2;
				SQ_START2: begin
					// [RULE_14] address off, service on
					addressOutTag <= 1'b0;
					serviceOutTag <= 1'b1;
					seqReg <= SQ_WAITSTA;
				end
				SQ_WAITSTA: begin
					if (statusValid) begin
						seqReg <= SQ_END1;
					end
				end
				SQ_END1: begin
					// [RULE_13] clear buffer
					commandOutTag <= 1'b0;
					seqReg <= SQ_END2;
				end
				SQ_END2: begin
					lockoutReg <= 1'b0;
					seqReg <= SQ_END3;
				end
				SQ_END3: begin
					transferReg <= RST_WORD;
					chanPriorityReq <= 1'b0;
					serviceOutTag <= 1'b0;
					selectOutTag <= 1'b0;
					seqReg <= SQ_IDLE;
				end
				SQ_ADRIN1: begin
					deviceReg <= busIn;
					seqReg <= SQ_ADRIN2;
				end
				SQ_ADRIN2: begin
					// [RULE_19] command tag and priority
					commandOutTag <= 1'b1;
					chanPriorityReq <= 1'b1;
					seqReg <= SQ_IDLE;
				end
				default: seqReg <= SQ_IDLE;
			endcase
		end
	end

	// -------------------------------------------------------------
	// storage port
	// -------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			storeAddr <= RST_WORD;
			storeData <= RST_WORD;
			storeWrUpper <= 1'b0;
			storeWrLower <= 1'b0;
		end else begin
			storeWrUpper <= 1'b0;
			storeWrLower <= 1'b0;
			if (allowReg && bootReg == BT_IDX) begin
				// [RULE_10] index into status word
				storeAddr <= STATUS_CW_ADDR;
				storeData <= indexReg;
				{storeWrUpper, storeWrLower} <= 2'h3;
			end else if (allowReg && bootReg == BT_CNT) begin
				storeAddr <= BCW_ADDR;
				storeData <= countReg;
				{storeWrUpper, storeWrLower} <= 2'h3;
			end else if (allowReg && bootReg == BT_ADR) begin
				// [RULE_11] address into control word
				storeAddr <= BCW_ADDR_HI;
				storeData <= dataAddrReg;
				{storeWrUpper, storeWrLower} <= 2'h3;
			end else if (statusStore || byteGo) begin
				// [RULE_09] even address upper lane
				storeAddr <= dataAddrReg;
				storeData <= statusStore ? {busIn, busIn} : {inputReg, inputReg};
				storeWrUpper <= ~dataAddrReg[0];
				storeWrLower <= dataAddrReg[0];
			end
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	AST_OP_STOP: assert property (@(posedge clock) disable iff (!resetn) // [RULE_01]
		lastByte && opReg == OP_STOP |=> bufDoneReg && !runReg) else $error("stop opcode missed");
	AST_WRAP: assert property (@(posedge clock) disable iff (!resetn) // [RULE_02]
		byteGo && addrWrap && !(wrAcc && address == OFS_DATA_ADDR) |=>
		dataAddrReg[15] != $past(dataAddrReg[15])) else $error("bit15 not toggled");
	AST_INDEX: assert property (@(posedge clock) disable iff (!resetn) // [RULE_03]
		chainStep && !(wrAcc && address == OFS_INDEX) |=> indexReg == $past(indexReg) + COUNT_ONE)
		else $error("index not stepped");
	AST_ZERO: assert property (@(posedge clock) disable iff (!resetn) // [RULE_05]
		lastByte && !wrAcc |=> countZeroReg && countReg == RST_WORD) else $error("count zero flag missing");
	AST_NULL: assert property (@(posedge clock) disable iff (!resetn) // [RULE_07]
		statusStore && busIn == RST_BYTE |=> nullStaReg) else $error("null status not flagged");
	AST_LANE: assert property (@(posedge clock) disable iff (!resetn) // [RULE_09]
		byteGo && !dataAddrReg[0] |=> storeWrUpper && !storeWrLower) else $error("wrong byte lane");
	AST_HOLD: assert property (@(posedge clock) disable iff (!resetn) // [RULE_12]
		bootReg != BT_IDLE && !allowReg |=> $stable(bootReg) && loadingReg) else $error("load ran unallowed");
	AST_BOOT_END: assert property (@(posedge clock) disable iff (!resetn) // [RULE_11]
		bootReg == BT_ADR && allowReg |=> waitReg && !loadingReg && storeAddr == BCW_ADDR_HI)
		else $error("last load step wrong");
	AST_END_SEQ: assert property (@(posedge clock) disable iff (!resetn) // [RULE_13]
		seqReg == SQ_END1 |=> seqReg == SQ_END2 ##1 seqReg == SQ_END3 && !lockoutReg ##1
		!chanPriorityReq && transferReg == RST_WORD && seqReg == SQ_IDLE) else $error("end status order");
	AST_START2: assert property (@(posedge clock) disable iff (!resetn) // [RULE_14]
		seqReg == SQ_START1 |=> ##1 !addressOutTag && serviceOutTag && selectOutTag)
		else $error("start status step two");
	AST_DESC: assert property (@(posedge clock) disable iff (!resetn) // [RULE_18]
		byteGo && descReg && !(wrAcc && address == OFS_DATA_ADDR) |=>
		dataAddrReg == $past(dataAddrReg) - COUNT_ONE) else $error("descending step wrong");
	AST_ADRIN: assert property (@(posedge clock) disable iff (!resetn) // [RULE_19]
		seqReg == SQ_ADRIN1 |=> ##1 commandOutTag && chanPriorityReq) else $error("address-in step two");
endmodule : ics_sequencer

// >>> ics_pkg.sv
package ics_pkg;
	// -------------------------------------------------------------
	// register map (byte addresses, word aligned)
	// -------------------------------------------------------------
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_FLAGS = 5'h04;
	localparam logic [4:0] OFS_DATA_ADDR = 5'h08;
	localparam logic [4:0] OFS_BYTE_COUNT = 5'h0C;
	localparam logic [4:0] OFS_INDEX = 5'h10;
	localparam logic [4:0] OFS_BCW = 5'h14;
	localparam logic [4:0] OFS_DEVICE = 5'h18;
	// control register bits
	localparam int CTL_DESC = 0;
	localparam int CTL_ALLOW = 1;
	localparam int CTL_RUN = 2;
	localparam int CTL_CMP_EN = 3;
	localparam int CTL_BOOT_GO = 8;
	localparam int CTL_STAT_GO = 9;
	// flag register bits
	localparam int FL_BUF_DONE = 0;
	localparam int FL_CTRL_BYTE = 1;
	localparam int FL_REJECT = 2;
	localparam int FL_NULL_STA = 3;
	localparam int FL_COUNT_ZERO = 4;
	localparam int FL_BIT15 = 5;
	localparam int FL_HELD = 6;
	localparam int FL_ATTN = 7;
	localparam int FL_UNIT_EXC = 8;
	localparam int FL_LOADING = 9;
	localparam int FL_WAIT = 10;
	localparam int FL_CHAIN_REQ = 11;
	localparam int FL_LOCKOUT = 12;
	// operation codes of the buffer control word
	localparam logic [1:0] OP_STOP = 2'h0;
	localparam logic [1:0] OP_CHAIN = 2'h1;
	localparam logic [1:0] OP_LINK = 2'h2;
	localparam logic [1:0] OP_STOP_NOW = 2'h3;
	// address steps
	localparam logic [2:0] STEP_BYTE = 3'h1;
	localparam logic [2:0] STEP_STATUS = 3'h4;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	// storage locations used by the bootstrap load
	localparam logic [15:0] STATUS_CW_ADDR = 16'h0000;
	localparam logic [15:0] BCW_ADDR = 16'h0004;
	localparam logic [15:0] BCW_ADDR_HI = 16'h0006;
	// reset values
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// sequencer states
	typedef enum logic [2:0] {BT_IDLE, BT_DEV, BT_XFER, BT_IDX, BT_CNT, BT_ADR} ics_boot_e;
	typedef enum logic [3:0] {SQ_IDLE, SQ_START1, SQ_START2, SQ_WAITSTA, SQ_END1, SQ_END2, SQ_END3,
		SQ_ADRIN1, SQ_ADRIN2} ics_seq_e;
endpackage : ics_pkg

// >>> ics_addr_step.sv
`timescale 1ns/1ps
// -------------------------------------------------------------
// address step with wrap toggle of the top bit
// -------------------------------------------------------------
module ics_addr_step
	import ics_pkg::*;
(
	// operand
	input wire logic [15:0] value,
	input wire logic descending,
	input wire logic [2:0] stepAmount,
	// result
	output logic [15:0] nextValue,
	output logic wrapCarry
);
	logic [15:0] lowSum;

	// low fifteen bits step, carry or borrow out toggles the top bit
	always_comb begin
		if (descending) begin
			lowSum = {1'b0, value[14:0]} - {13'h0000, stepAmount};
		end else begin
			lowSum = {1'b0, value[14:0]} + {13'h0000, stepAmount};
		end
		wrapCarry = lowSum[15];
		nextValue = {value[15] ^ wrapCarry, lowSum[14:0]};
	end
endmodule : ics_addr_step

// >>> ics_periph_model.sv
`timescale 1ns/1ps
// -------------------------------------------------------------
// peripheral control unit model
// -------------------------------------------------------------
module ics_periph_model
	import ics_pkg::*;
#(parameter int STATUS_DELAY = 3)
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// tags from the channel
	input wire logic selectOutTag,
	input wire logic serviceOutTag,
	// lines to the channel
	output logic [7:0] busIn,
	output logic dataInValid,
	output logic statusValid,
	output logic addressInTag,
	output logic rejectIn
);
	logic [7:0] statusByte = 8'h00;
	logic answered = 1'b0;
	int waitCnt = 0;

	// quiet lines at time zero
	initial begin
		busIn = 8'hFF;
		dataInValid = 1'b0;
		statusValid = 1'b0;
		addressInTag = 1'b0;
	end
	assign rejectIn = 1'b0;

	// one strobed byte: kind 0 data, kind 1 device number
	task automatic strobe(input logic [7:0] v, input logic kind);
		@(posedge clock);
		busIn <= v;
		dataInValid <= !kind;
		addressInTag <= kind;
		@(posedge clock);
		// device number must still stand while the channel latches it
		if (kind)
			@(posedge clock);
		busIn <= ~v; // released bus shows no stale byte
		dataInValid <= 1'b0;
		addressInTag <= 1'b0;
	endtask : strobe

	// status reply after a delay, once per service request
	// answer raised tags only
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			statusValid <= 1'b0;
			answered <= 1'b0;
			waitCnt <= 0;
		end else begin
			statusValid <= 1'b0;
			if (statusValid)
				busIn <= ~busIn;
			if (!(serviceOutTag && selectOutTag)) begin
				answered <= 1'b0;
				waitCnt <= 0;
			end else if (!answered) begin
				if (waitCnt == STATUS_DELAY) begin
					busIn <= statusByte;
					statusValid <= 1'b1;
					answered <= 1'b1;
				end else
					waitCnt <= waitCnt + 1;
			end
		end
	end
endmodule : ics_periph_model

// >>> tb_top.sv
`timescale 1ns/1ps
// -------------------------------------------------------------
// channel sequencer testbench
// -------------------------------------------------------------
module tb_top
	import ics_pkg::*;
;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] BOOT_EXP [3] = '{32'h00000007, 32'h00040056, 32'h00061234};
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 32'h0, readdata, rdat;
	logic read = 1'b0, write = 1'b0, attnSwitch = 1'b0, unitExcSwitch = 1'b0;
	logic waitrequest, dataInValid, statusValid, addressInTag, rejectIn;
	logic selectOutTag, addressOutTag, serviceOutTag, commandOutTag, chanPriorityReq;
	logic [15:0] storeAddr, storeData;
	logic storeWrUpper, storeWrLower;
	logic [7:0] busIn;
	logic [15:0] addrLog [64];
	logic [15:0] dataLog [64];
	logic [1:0] laneLog [64];
	int stores = 0, overlap = 0, failures = 0, compares = 0;

	// clock
	always #5 clock = ~clock;

	ics_sequencer dut (.clock, .resetn, .address, .read, .write, .writedata, .readdata, .waitrequest, .busIn,
		.dataInValid, .statusValid, .addressInTag, .rejectIn, .attnSwitch, .unitExcSwitch, .selectOutTag,
		.addressOutTag, .serviceOutTag, .commandOutTag, .chanPriorityReq, .storeAddr, .storeData,
		.storeWrUpper, .storeWrLower);
	ics_periph_model peer (.clock, .resetn, .selectOutTag, .serviceOutTag, .busIn, .dataInValid,
		.statusValid, .addressInTag, .rejectIn);

	// log storage writes, count tag overlaps
	always @(posedge clock) begin
		if (storeWrUpper || storeWrLower) begin
			addrLog[stores[5:0]] <= storeAddr;
			dataLog[stores[5:0]] <= storeData;
			laneLog[stores[5:0]] <= {storeWrUpper, storeWrLower};
			stores <= stores + 1;
		end
		if (serviceOutTag && addressOutTag)
			overlap <= overlap + 1;
	end

	// -------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one access, held until waitrequest is seen low; the watchdog bounds a hang
	task automatic access(input logic [4:0] a, input logic rd, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		read <= rd;
		write <= !rd;
		writedata <= d;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		rdat = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : access

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		access(a, 1'b0, d);
	endtask : wr

	task automatic rdm(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
		access(a, 1'b1, 32'h0);
		check(rdat & mask, exp);
	endtask : rdm

	// bounded wait for a count of storage writes
	task automatic waitStores(input int n);
		int k;
		k = 0;
		while (stores < n && k < 50) begin
			@(posedge clock);
			k++;
		end
		check(stores, n);
	endtask : waitStores

	task automatic complete_run;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// watchdog
	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		complete_run();
	end

	// -------------------------------------------------------------
	// tests
	// -------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		rdm(OFS_FLAGS, ALL, 32'h0);
		rdm(OFS_CTRL, ALL, 32'h0);
		rdm(5'h1C, ALL, 32'h0);
		// wrap across bit 15, odd then even lane
		wr(OFS_DATA_ADDR, 32'h7FFF);
		wr(OFS_BYTE_COUNT, 32'h2);
		wr(OFS_BCW, 32'h0);
		wr(OFS_CTRL, 32'h4);
		peer.strobe(8'hA5, 1'b0);
		waitStores(1);
		check({addrLog[0], dataLog[0]}, 32'h7FFFA5A5);
		check(laneLog[0], 32'h1);
		rdm(OFS_DATA_ADDR, ALL, 32'h8000);
		rdm(OFS_FLAGS, 32'h71, 32'h20);
		peer.strobe(8'h3C, 1'b0);
		waitStores(2);
		check({laneLog[1], dataLog[1]}, 32'h23C3C);
		rdm(OFS_FLAGS, 32'h71, 32'h31);
		rdm(OFS_CTRL, 32'h4, 32'h0);
		// every operation code ending a one-byte buffer
		for (int op = 0; op < 4; op++) begin
			wr(OFS_FLAGS, 32'hFFF);
			wr(OFS_INDEX, 32'h0);
			wr(OFS_BYTE_COUNT, 32'h1);
			wr(OFS_BCW, op);
			wr(OFS_CTRL, 32'h4);
			peer.strobe(8'h01, 1'b0);
			waitStores(3 + op);
			rdm(OFS_FLAGS, 32'h801, {op == 1 || op == 2, 10'h0, op == 0});
			rdm(OFS_CTRL, 32'h4, (op == 1 || op == 2) ? 32'h4 : 32'h0);
			rdm(OFS_INDEX, ALL, op == 1);
		end
		// held byte, overrun, then compare match
		wr(OFS_CTRL, 32'h0);
		wr(OFS_FLAGS, 32'hFFF);
		peer.strobe(8'h11, 1'b0);
		rdm(OFS_FLAGS, 32'h44, 32'h40);
		peer.strobe(8'h22, 1'b0);
		rdm(OFS_FLAGS, 32'h44, 32'h44);
		wr(OFS_BCW, 32'h1100);
		wr(OFS_BYTE_COUNT, 32'h2);
		wr(OFS_CTRL, 32'hC);
		waitStores(7);
		check(dataLog[6], 32'h1111);
		rdm(OFS_FLAGS, 32'h42, 32'h02);
		// status sequence, descending, null status
		attnSwitch <= 1'b1;
		unitExcSwitch <= 1'b1;
		@(posedge clock);
		attnSwitch <= 1'b0;
		unitExcSwitch <= 1'b0;
		rdm(OFS_FLAGS, 32'h180, 32'h180);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_DATA_ADDR, 32'h10);
		wr(OFS_CTRL, 32'h201);
		waitStores(8);
		check({addrLog[7], dataLog[7]}, 32'h00100000);
		rdm(OFS_DATA_ADDR, ALL, 32'hC);
		rdm(OFS_FLAGS, 32'h1188, 32'h8);
		check({selectOutTag, addressOutTag, serviceOutTag, chanPriorityReq}, 32'h0);
		check(overlap, 32'h0);
		// descending byte store, even address upper lane
		wr(OFS_BYTE_COUNT, 32'h1);
		wr(OFS_CTRL, 32'h5);
		peer.strobe(8'h66, 1'b0);
		waitStores(9);
		check({laneLog[8], dataLog[8]}, 32'h26666);
		rdm(OFS_DATA_ADDR, ALL, 32'hB);
		// address-in: command tag and priority request
		peer.strobe(8'h5C, 1'b1);
		rdm(OFS_DEVICE, 32'hFF, 32'h5C);
		check({commandOutTag, chanPriorityReq}, 32'h3);
		repeat (8) @(posedge clock);
		check({commandOutTag, chanPriorityReq}, 32'h3);
		// bootstrap load, frozen once by dropping allow
		wr(OFS_DATA_ADDR, 32'h1234);
		wr(OFS_BYTE_COUNT, 32'h56);
		wr(OFS_INDEX, 32'h7);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL, 32'h102);
		wr(OFS_CTRL, 32'h0);
		rdm(OFS_FLAGS, 32'h600, 32'h200);
		check(stores, 32'hA);
		wr(OFS_CTRL, 32'h2);
		waitStores(12);
		for (int i = 0; i < 3; i++)
			check({addrLog[9 + i], dataLog[9 + i]}, BOOT_EXP[i]);
		check(laneLog[11], 32'h3);
		rdm(OFS_FLAGS, 32'h600, 32'h400);
		rdm(OFS_DEVICE, ALL, 32'h00005C5C);
		complete_run();
	end
endmodule : tb_top
